// file: ais_pkg.sv
// Package with register map, field layout and encodings for the input select block.
package ais_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [3:0] OFF_AUX_SEL  = 4'h0;
    localparam logic [3:0] OFF_ZERO_SEL = 4'h4;
    localparam logic [3:0] OFF_SCAN     = 4'h8;
    localparam logic [3:0] OFF_PIN_ANALOG_DIGITAL_CONFIG     = 4'hC;
    localparam logic [3:0] OFF_CTRL     = 4'h0;
    localparam logic [3:0] OFF_STATUS   = 4'h4;

    // Writable bit masks; all other bits read as zero.
    localparam logic [15:0] MASK_AUX  = 16'h0707;
    localparam logic [15:0] MASK_ZERO = 16'h9F9F;
    localparam logic [15:0] MASK_SCAN = 16'h1FFF;
    localparam logic [15:0] MASK_PIN_ANALOG_DIGITAL_CONFIG = 16'h1FFF;
    localparam logic [15:0] MASK_CTRL = 16'h001F;
    localparam logic [15:0] RST_VAL   = 16'h0000;

    // Field positions in the auxiliary channel select register.
    localparam int AUX_POS_A   = 0;
    localparam int AUX_NEG_A   = 1;
    localparam int AUX_POS_B   = 8;
    localparam int AUX_NEG_B   = 9;
    // Field positions in the channel zero select register.
    localparam int ZERO_POS_A  = 0;
    localparam int ZERO_NEG_A  = 7;
    localparam int ZERO_POS_B  = 8;
    localparam int ZERO_NEG_B  = 15;
    // Field positions in the control register.
    localparam int CTRL_RES    = 0;
    localparam int CTRL_ALT    = 1;
    localparam int CTRL_SCAN   = 2;
    localparam int CTRL_CHANNEL_COUNT_SELECT   = 3;

    localparam int NUM_INPUTS  = 13;

    // Multiplexer codes: 0..12 analog inputs, then reference and ground.
    localparam logic [4:0] MUX_VREF_N = 5'h1E;
    localparam logic [4:0] MUX_AVSS   = 5'h1F;
    localparam logic [4:0] MAX_INPUT  = 5'h0C;
    localparam logic [4:0] RSV_LO     = 5'h06;
    localparam logic [4:0] RSV_HI     = 5'h08;

    // Auxiliary negative select codes.
    localparam logic [1:0] NEG_HIGH_SET = 2'h3;
    localparam logic [1:0] NEG_MID_SET  = 2'h2;

    // Channel count codes and the channel one to three enables they give.
    localparam logic [1:0] CHANNEL_COUNT_SELECT_CH0  = 2'h0;
    localparam logic [1:0] CHANNEL_COUNT_SELECT_CH01 = 2'h1;
    localparam logic [2:0] EN_NONE   = 3'h0;
    localparam logic [2:0] EN_CH1    = 3'h1;
    localparam logic [2:0] EN_ALL    = 3'h7;

    localparam logic [4:0] AN0 = 5'h00;
    localparam logic [4:0] AN1 = 5'h01;
    localparam logic [4:0] AN3 = 5'h03;
    localparam logic [4:0] AN6 = 5'h06;
    localparam logic [4:0] AN9 = 5'h09;

    typedef enum logic [1:0] {
        PH_A = 2'b00,
        PH_B = 2'b01
    } ais_phase_type;
endpackage

// file: ais_input_select.sv
// Register file and multiplexer select decoding for the converter input channels.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ais_input_select #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Sample strobe from the conversion sequencer
    input  wire logic        sample_i,
    // Multiplexer selects
    output logic [4:0]       zero_pos_o,
    output logic [4:0]       zero_neg_o,
    output logic [14:0]      aux_pos_o,
    output logic [14:0]      aux_neg_o,
    output logic [2:0]       aux_enable_o,
    output logic             phase_b_o,
    // Pin configuration
    output logic [12:0]      pin_digital_o
);
    logic [15:0] aux_sel_q, zero_sel_q, scan_q, pin_analog_digital_config_q, ctrl_q;
    logic [4:0]  scan_ptr_q;
    ais_pkg::ais_phase_type phase_q;
    logic        hit;
    logic        req;
    logic [15:0] wdata;
    // Per-register write strobes.
    logic        wr_aux;
    logic        wr_zero;
    logic        wr_scan;
    logic        wr_pin_analog_digital_config;
    logic        wr_ctrl;
    // Fields of the sample phase in use.
    logic        res12;
    logic        pb;
    logic [4:0]  zp;
    logic [1:0]  ncode;
    logic        pbit;
    logic [1:0]  channel_count_select;
    logic        zneg;
    logic [15:0] rdata;
    logic [4:0]  next_scan;

    // Byte enables apply per lane; only the low 16 bits carry data.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (sel_i[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (sel_i[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v & mask;
    endfunction

    // Positive select for channels one to three; reserved in 12-bit mode.
    function automatic logic [4:0] aux_pos(input logic bitv, input logic [1:0] ch,
                                           input logic res12);
        logic [4:0] base;
        base = bitv ? ais_pkg::AN3 : ais_pkg::AN0;
        if (res12) begin
            return ais_pkg::MUX_VREF_N;
        end
        return base + {3'h0, ch};
    endfunction

    function automatic logic [4:0] aux_neg(input logic [1:0] code, input logic [1:0] ch,
                                           input logic res12);
        logic [4:0] r;
        r = ais_pkg::MUX_VREF_N;
        if (res12) begin
            r = ais_pkg::MUX_VREF_N;
        end else if (code == ais_pkg::NEG_HIGH_SET) begin
            r = ais_pkg::AN9 + {3'h0, ch};
        end else if (code == ais_pkg::NEG_MID_SET && LARGE_VARIANT) begin
            r = ais_pkg::AN6 + {3'h0, ch};
        end
        return r;
    endfunction

    // Analog input actually available, or the reference for absent or reserved codes.
    function automatic logic [4:0] zero_pos(input logic [4:0] code);
        logic [4:0] r;
        r = code;
        if (code > ais_pkg::MAX_INPUT) begin
            r = ais_pkg::MUX_VREF_N;
        end else if (!LARGE_VARIANT && code >= ais_pkg::RSV_LO && code <= ais_pkg::RSV_HI) begin
            r = ais_pkg::MUX_VREF_N;
        end
        return r;
    endfunction

    // A digital pin feeds ground to the multiplexer instead of its voltage.
    function automatic logic [4:0] pin_gate(input logic [4:0] code);
        logic [4:0] r;
        r = code;
        if (code <= ais_pkg::MAX_INPUT && pin_analog_digital_config_q[code[3:0]]) begin
            r = ais_pkg::MUX_AVSS;
        end
        return r;
    endfunction

    assign req   = cyc_i && stb_i && !ack_o;
    assign hit   = adr_i[4] == 1'b0;
    assign wdata = dat_i[15:0];

    // Register match by half and offset, shared by the read and write decoders.
    // The main registers sit in the lower half of the window, the block's own above.
    function automatic logic adr_is(input logic main, input logic [3:0] off);
        return (main == hit) && (adr_i[3:0] == off);
    endfunction

    // Channels one to three in use; 12-bit mode converts channel zero alone.
    function automatic logic [2:0] aux_en(input logic [1:0] count, input logic res);
        logic [2:0] e;
        e = ais_pkg::EN_ALL;
        if (res || count == ais_pkg::CHANNEL_COUNT_SELECT_CH0) begin
            e = ais_pkg::EN_NONE;
        end else if (count == ais_pkg::CHANNEL_COUNT_SELECT_CH01) begin
            e = ais_pkg::EN_CH1;
        end
        return e;
    endfunction

    // Read multiplexer; holes in the map read zero.
    always_comb begin
        rdata = 16'h0000;
        if (adr_is(1'b0, ais_pkg::OFF_CTRL)) begin
            rdata = ctrl_q;
        end else if (adr_is(1'b0, ais_pkg::OFF_STATUS)) begin
            rdata = {10'h000, phase_q == ais_pkg::PH_B, scan_ptr_q};
        end else if (adr_is(1'b1, ais_pkg::OFF_AUX_SEL)) begin
            rdata = aux_sel_q;
        end else if (adr_is(1'b1, ais_pkg::OFF_ZERO_SEL)) begin
            rdata = zero_sel_q;
        end else if (adr_is(1'b1, ais_pkg::OFF_SCAN)) begin
            rdata = scan_q;
        end else if (adr_is(1'b1, ais_pkg::OFF_PIN_ANALOG_DIGITAL_CONFIG)) begin
            rdata = pin_analog_digital_config_q;
        end
    end

    // One strobe per register; a write to a hole or to status is acked and dropped.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_aux  = 1'b0;
        wr_zero = 1'b0;
        wr_scan = 1'b0;
        wr_pin_analog_digital_config = 1'b0;
        if (req && we_i) begin
            if (adr_is(1'b0, ais_pkg::OFF_CTRL)) begin
                wr_ctrl = 1'b1;
            end else if (adr_is(1'b1, ais_pkg::OFF_AUX_SEL)) begin
                wr_aux = 1'b1;
            end else if (adr_is(1'b1, ais_pkg::OFF_ZERO_SEL)) begin
                wr_zero = 1'b1;
            end else if (adr_is(1'b1, ais_pkg::OFF_SCAN)) begin
                wr_scan = 1'b1;
            end else if (adr_is(1'b1, ais_pkg::OFF_PIN_ANALOG_DIGITAL_CONFIG)) begin
                wr_pin_analog_digital_config = 1'b1;
            end
        end
    end

    // Single-cycle answer, so a master never waits more than one edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data is registered with the acknowledge and stands for that cycle only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else begin
            dat_o <= {16'h0000, rdata};
        end
    end

    // Control register of the block's own half.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= ais_pkg::RST_VAL;
        end else if (wr_ctrl) begin
            ctrl_q <= merge(ctrl_q, ais_pkg::MASK_CTRL);
        end
    end

    // Auxiliary channel selects; unimplemented bits are masked on the way in.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_sel_q <= ais_pkg::RST_VAL;
        end else if (wr_aux) begin
            aux_sel_q <= merge(aux_sel_q, ais_pkg::MASK_AUX);
        end
    end

    // Channel zero selects.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_sel_q <= ais_pkg::RST_VAL;
        end else if (wr_zero) begin
            zero_sel_q <= merge(zero_sel_q, ais_pkg::MASK_ZERO);
        end
    end

    // Scan mask; bits of absent inputs are kept and resolved at decode time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_q <= ais_pkg::RST_VAL;
        end else if (wr_scan) begin
            scan_q <= merge(scan_q, ais_pkg::MASK_SCAN);
        end
    end

    // Pin configuration; all thirteen bits stay writable on every variant.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_analog_digital_config_q <= ais_pkg::RST_VAL;
        end else if (wr_pin_analog_digital_config) begin
            pin_analog_digital_config_q <= merge(pin_analog_digital_config_q, ais_pkg::MASK_PIN_ANALOG_DIGITAL_CONFIG);
        end
    end

    // Next set scan bit above the pointer, wrapping to the lowest one.
    always_comb begin
        next_scan = scan_ptr_q;
        for (int k = ais_pkg::NUM_INPUTS; k >= 1; k--) begin
            if (scan_q[(int'(scan_ptr_q) + k) % ais_pkg::NUM_INPUTS]) begin
                next_scan = 5'((int'(scan_ptr_q) + k) % ais_pkg::NUM_INPUTS);
            end
        end
    end

    // The phase advances on each sample strobe; without alternation it rests in A.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= ais_pkg::PH_A;
        end else if (sample_i) begin
            if (ctrl_q[ais_pkg::CTRL_ALT] && phase_q == ais_pkg::PH_A) begin
                phase_q <= ais_pkg::PH_B;
            end else begin
                phase_q <= ais_pkg::PH_A;
            end
        end
    end

    // The scan pointer moves only on phase A samples, which are the scanned ones.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_ptr_q <= ais_pkg::AN0;
        end else if (sample_i && phase_q == ais_pkg::PH_A && ctrl_q[ais_pkg::CTRL_SCAN]) begin
            scan_ptr_q <= next_scan;
        end
    end

    // Fields of the phase in use; scanning overrides the channel zero input in phase A.
    always_comb begin
        res12 = ctrl_q[ais_pkg::CTRL_RES];
        pb    = phase_q == ais_pkg::PH_B;
        channel_count_select  = ctrl_q[ais_pkg::CTRL_CHANNEL_COUNT_SELECT +: 2];
        if (pb) begin
            zp    = zero_sel_q[ais_pkg::ZERO_POS_B +: 5];
            ncode = aux_sel_q[ais_pkg::AUX_NEG_B +: 2];
            pbit  = aux_sel_q[ais_pkg::AUX_POS_B];
            zneg  = zero_sel_q[ais_pkg::ZERO_NEG_B];
        end else begin
            zp    = zero_sel_q[ais_pkg::ZERO_POS_A +: 5];
            ncode = aux_sel_q[ais_pkg::AUX_NEG_A +: 2];
            pbit  = aux_sel_q[ais_pkg::AUX_POS_A];
            zneg  = zero_sel_q[ais_pkg::ZERO_NEG_A];
        end
        if (!pb && ctrl_q[ais_pkg::CTRL_SCAN]) begin
            zp = scan_ptr_q;
        end
    end

    // Channel zero positive select; registered so the multiplexer never sees a glitch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_pos_o <= ais_pkg::MUX_VREF_N;
        end else begin
            zero_pos_o <= pin_gate(zero_pos(zp));
        end
    end

    // Channel zero negative select.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_neg_o <= ais_pkg::MUX_VREF_N;
        end else if (zneg) begin
            zero_neg_o <= pin_gate(ais_pkg::AN1);
        end else begin
            zero_neg_o <= ais_pkg::MUX_VREF_N;
        end
    end

    // Channels one to three; their selects are driven even when the channel is unused.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_pos_o <= {3{ais_pkg::MUX_VREF_N}};
            aux_neg_o <= {3{ais_pkg::MUX_VREF_N}};
        end else begin
            for (int c = 0; c < 3; c++) begin
                aux_pos_o[c*5 +: 5] <= pin_gate(aux_pos(pbit, 2'(c), res12));
                aux_neg_o[c*5 +: 5] <= pin_gate(aux_neg(ncode, 2'(c), res12));
            end
        end
    end

    // Channel enables follow the channel count field; 12-bit mode turns all three off.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_enable_o <= ais_pkg::EN_NONE;
        end else begin
            aux_enable_o <= aux_en(channel_count_select, res12);
        end
    end

    // Phase indicator for the sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_b_o <= 1'b0;
        end else begin
            phase_b_o <= pb;
        end
    end

    // Pin modes; a pin configured digital also feeds ground to the multiplexers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_digital_o <= 13'h0000;
        end else begin
            pin_digital_o <= pin_analog_digital_config_q[ais_pkg::NUM_INPUTS-1:0];
        end
    end
endmodule

// file: ais_input_select_sva.sv
// Checker for the bus handshake and the select codes of the input select block.
`timescale 1ns/1ps
module ais_input_select_sva (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Sample strobe and selects
    input wire logic        sample_i,
    input wire logic [4:0]  zero_pos_o,
    input wire logic [4:0]  zero_neg_o,
    input wire logic [14:0] aux_pos_o,
    input wire logic [14:0] aux_neg_o,
    input wire logic [2:0]  aux_enable_o,
    input wire logic        phase_b_o,
    input wire logic [12:0] pin_digital_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    a_read_high_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_pin_analog_digital_config_to_pins: assert property (cyc_i && stb_i && we_i && !ack_o && adr_i == 5'h0C
        && sel_i[1:0] == 2'h3 |-> ##2 pin_digital_o == $past(dat_i[12:0], 2))
        else $error("pin mode not updated");
    a_zero_neg_codes: assert property (zero_neg_o inside {5'h01, 5'h1E, 5'h1F})
        else $error("bad zero negative code");
    a_zero_pos_range: assert property (zero_pos_o <= 5'h0C || zero_pos_o >= 5'h1E)
        else $error("bad zero positive code");
    a_aux_neg_codes: assert property (aux_neg_o[4:0] inside {5'h06, 5'h09, 5'h1E, 5'h1F})
        else $error("bad aux negative code");
    a_aux_pos_codes: assert property (aux_pos_o[4:0] inside {5'h00, 5'h03, 5'h1E, 5'h1F})
        else $error("bad aux positive code");
    a_phase_has_cause: assert property ($changed(phase_b_o) |-> $past(sample_i)
        || $past(sample_i, 2) || $past(ack_o) || $past(ack_o, 2))
        else $error("phase changed without cause");
endmodule
bind ais_input_select ais_input_select_sva i_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sample_i, .zero_pos_o, .zero_neg_o,
    .aux_pos_o, .aux_neg_o, .aux_enable_o, .phase_b_o, .pin_digital_o);

// file: ais_mux_model.sv
// Behavioural sample-and-hold stage that pulses a sample and keeps the code it saw.
`timescale 1ns/1ps
module ais_mux_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Sample request and channel zero code
    input  wire logic       take_i,
    input  wire logic [4:0] zero_pos_i,
    // Sample pulse and held code
    output logic            sample_o,
    output logic [4:0]      held_o
);
    // The held code is what was really converted, so a select that moves late shows up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_o <= 1'b0;
            held_o   <= 5'h1E;
        end else begin
            sample_o <= take_i;
            if (take_i) begin
                held_o <= zero_pos_i;
            end
        end
    end
endmodule

// file: ais_input_select_tb.sv
// Self-checking bench for the converter input select block.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
module ais_input_select_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic        take  = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'h3;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack_o;
    logic        phase_b_o;
    logic        sample_i;
    logic [4:0]  zero_pos_o;
    logic [4:0]  zero_neg_o;
    logic [4:0]  held;
    logic [4:0]  p;
    logic [14:0] aux_pos_o;
    logic [14:0] aux_neg_o;
    logic [2:0]  aux_enable_o;
    logic [12:0] pin_digital_o;
    logic [15:0] ra;
    logic [15:0] rz;
    logic [15:0] rp;
    int          n_errors = 0;
    int          n_tests = 0;
    int          seed = 75832;
    always #4 clk_i = ~clk_i;
    ais_input_select i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .sample_i, .zero_pos_o, .zero_neg_o, .aux_pos_o, .aux_neg_o,
        .aux_enable_o, .phase_b_o, .pin_digital_o);
    ais_mux_model i_mux (.clk_i, .rst_i, .take_i(take), .zero_pos_i(zero_pos_o),
        .sample_o(sample_i), .held_o(held));
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // The slave answers one cycle after taking a request; the bound only cuts a hang.
    task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (ack_o !== 1'b1) begin
            `CHK("ack", 1'b1, ack_o)
            conclude();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        `CHK(nm, {16'h0000, e}, rd)
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulse();
        @(posedge clk_i);
        take <= 1'b1;
        @(posedge clk_i);
        take <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    function automatic logic [4:0] sub(input logic [4:0] v);
        return (v <= 5'h0C && rp[v]) ? 5'h1F : v;
    endfunction
    function automatic logic [4:0] nxt(input logic [4:0] q);
        for (int k = 1; k <= 13; k++) if ((16'h1124 >> ((q + k) % 13)) & 1) return 5'((q + k) % 13);
        return q;
    endfunction
    task automatic chk_sel(input logic [2:0] f, input logic [7:0] z);
        logic [4:0] n;
        for (int c = 0; c < 3; c++) begin
            n = f[2:1] == 2'h3 ? 5'h09 + 5'(c) : f[2:1] == 2'h2 ? 5'h06 + 5'(c) : 5'h1E;
            `CHK("aux_neg", sub(n), aux_neg_o[5*c +: 5])
            `CHK("aux_pos", sub(5'(3 * f[0] + c)), aux_pos_o[5*c +: 5])
        end
        `CHK("zero_pos", z[4:0] > 5'h0C ? 5'h1E : sub(z[4:0]), zero_pos_o)
        `CHK("zero_neg", z[7] ? sub(5'h01) : 5'h1E, zero_neg_o)
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 28; a += 4) rdchk("reset", 5'(a), 16'h0000);
        for (int i = 0; i < 12; i++) begin
            ra = i == 0 ? 16'hFFFF : 16'($random(seed));
            rz = i == 0 ? 16'h8C8C : i == 1 ? 16'h0D06 : 16'($random(seed));
            rp = i < 2 ? 16'hE000 : 16'($random(seed) & $random(seed) & $random(seed));
            wr(5'h00, ra);
            wr(5'h04, rz);
            wr(5'h08, rp);
            wr(5'h0C, rp);
            wr(5'h10, 16'h0010);
            rdchk("aux_reg", 5'h00, ra & ais_pkg::MASK_AUX);
            rdchk("zero_reg", 5'h04, rz & ais_pkg::MASK_ZERO);
            rdchk("scan_reg", 5'h08, rp & ais_pkg::MASK_SCAN);
            rdchk("pin_analog_digital_config_reg", 5'h0C, rp & ais_pkg::MASK_PIN_ANALOG_DIGITAL_CONFIG);
            rp = rp & ais_pkg::MASK_PIN_ANALOG_DIGITAL_CONFIG;
            settle();
            `CHK("pins", rp[12:0], pin_digital_o)
            `CHK("phase_a", 1'b0, phase_b_o)
            chk_sel(ra[2:0], rz[7:0]);
            wr(5'h10, 16'h0012);
            pulse();
            `CHK("phase_b", 1'b1, phase_b_o)
            chk_sel(ra[10:8], rz[15:8]);
            wr(5'h10, 16'h0011);
            settle();
            `CHK("aux_12b", 15'h7BDE, aux_pos_o)
            pulse();
        end
        for (int c = 0; c < 4; c++) begin
            wr(5'h10, 16'(c << 3));
            settle();
            `CHK("aux_enable", c[1] ? 3'h7 : {2'h0, c[0]}, aux_enable_o)
        end
        rp = 16'h0000;
        wr(5'h0C, rp);
        wr(5'h08, 16'h1124);
        wr(5'h10, 16'h0014);
        p = 5'h00;
        for (int j = 0; j < 6; j++) begin
            settle();
            `CHK("scan_pos", p, zero_pos_o)
            pulse();
            `CHK("scan_held", p, held)
            p = nxt(p);
            rdchk("scan_ptr", 5'h14, {11'h000, p});
        end
        conclude();
    end
endmodule
